// ===== dv/srd_host.sv
// host model that drives frames on the serial pins
`timescale 1ns/1ns
module srd_host (
    input wire logic clk,
    output logic serialClk,
    output logic frameSyncN,
    output logic serialIn,
    input wire logic serialOut
);
    // serial clock stands low outside frames
    initial begin
        serialClk = 1'b0;
        frameSyncN = 1'b1;
        serialIn = 1'b0;
    end
    // all pin moves land just after a clk edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // n bits msb first; 4 clk half period gives the 400 ns link clock
    task automatic frame(input logic [15:0] w, input int n,
            output logic [15:0] r);
        r = 16'h0000;
        frameSyncN = 1'b0;
        tick(4);
        for (int i = 15; i > 15 - n; i--) begin
            serialIn = w[i];
            r[i] = serialOut; // bit settled since the last fall
            serialClk = 1'b1;
            tick(4);
            serialClk = 1'b0;
            tick(4);
        end
        serialIn = ~serialIn; // released line must not echo the last bit
        frameSyncN = 1'b1;
        tick(4);
    endtask
endmodule // srd_host

// ===== dv/srd_monitor.sv
// pin level assertions for the serial register block
`timescale 1ns/1ns
module srd_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic frameSyncN,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic [11:0] convResult,
    input wire logic [15:0] devStatus,
    input wire logic [13:0] controlWord,
    input wire logic [13:0] testWord,
    input wire logic writeDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // link idle long enough for the synchroniser to settle
    sequence s_link_idle;
        frameSyncN [*4];
    endsequence
    // serial clock seen high two cycles back, with frame sync low three cycles back
    sequence s_rise_in_frame;
        $past(serialClk, 2) && !$past(frameSyncN, 3);
    endsequence
    a_ctrl_on_done: assert property (
        !$stable(controlWord) |-> writeDone) else $error("ctrl moved");
    a_test_on_done: assert property (
        !$stable(testWord) |-> writeDone) else $error("test moved");
    a_one_target: assert property (
        !$stable(controlWord) |-> $stable(testWord))
        else $error("two targets");
    a_done_pulse: assert property (
        writeDone |=> !writeDone [*8]) else $error("done too often");
    a_done_in_frame: assert property (
        writeDone |-> s_rise_in_frame) else $error("done without rise");
    a_out_idle: assert property (
        s_link_idle |-> $stable(serialOut)) else $error("out moved idle");
    a_out_on_fall: assert property (
        $changed(serialOut) |-> !$past(serialClk, 2) && !$past(serialClk, 3))
        else $error("out moved on rise");
    a_reset_clear: assert property (
        $fell(rst) |-> controlWord == 14'h0000 && testWord == 14'h0000)
        else $error("reset values");
endmodule // srd_monitor
bind srd_top srd_monitor chk_u (.clk(clk), .rst(rst),
    .serialClk(serialClk), .frameSyncN(frameSyncN), .serialIn(serialIn),
    .serialOut(serialOut), .convResult(convResult), .devStatus(devStatus),
    .controlWord(controlWord), .testWord(testWord), .writeDone(writeDone));

// ===== dv/test_srd_top.sv
// self-checking bench for the serial register block
`timescale 1ns/1ns
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("wrong value at %0t: got %h", $time, (g)); \
    end \
end
module test_srd_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic serialClk, frameSyncN, serialIn, serialOut, writeDone;
    logic [11:0] convResult = 12'hA5C;
    logic [15:0] devStatus = 16'h8E31;
    logic [13:0] controlWord, testWord;
    logic [15:0] rd;
    int err_count = 0;
    int checks_done = 0;
    always #25 clk = ~clk;
    srd_top dut_u (.clk(clk), .rst(rst), .serialClk(serialClk),
        .frameSyncN(frameSyncN), .serialIn(serialIn), .serialOut(serialOut),
        .convResult(convResult), .devStatus(devStatus),
        .controlWord(controlWord), .testWord(testWord),
        .writeDone(writeDone));
    srd_host host_u (.clk(clk), .serialClk(serialClk),
        .frameSyncN(frameSyncN), .serialIn(serialIn), .serialOut(serialOut));
    // write the control word, which also sets read select
    task automatic ctrl(input logic [13:0] v);
        host_u.frame({srd_pkg::ADDR_CTRL, v}, 16, rd);
        `CHK(controlWord, v)
    endtask
    // address 00 frame: default read, nothing stored
    task automatic t_defaults();
        host_u.frame(16'h3FFF, 16, rd);
        `CHK(rd, {4'h0, convResult})
        `CHK(controlWord, 14'h0000)
        `CHK(testWord, 14'h0000)
    endtask
    // frame cut short after 8 bits must leave control alone
    task automatic t_short();
        host_u.frame(16'hFFFF, 8, rd);
        `CHK(controlWord, 14'h0000)
    endtask
    // test word written, then read twice while result moves
    task automatic t_test();
        // the run's only test word write, a factory-style access
        host_u.frame({srd_pkg::ADDR_TEST, 14'h2A5B}, 16, rd);
        `CHK(testWord, 14'h2A5B)
        ctrl(14'h0040);
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, 16'h2A5B)
        convResult = 12'h3C1;
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, 16'h2A5B)
        `CHK(testWord, 14'h2A5B)
    endtask
    // calibration slot 2 written, slot 1 stays clear
    task automatic t_cal();
        ctrl(14'h0084);
        host_u.frame({srd_pkg::ADDR_CAL, 14'h1234}, 16, rd);
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, 16'h1234)
        ctrl(14'h0082);
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, 16'h0000)
    endtask
    // status source, then a channel-only write returns to the result
    task automatic t_status();
        ctrl(14'h00C0);
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, devStatus)
        ctrl(14'h2C00);
        host_u.frame(16'h0000, 16, rd);
        `CHK(rd, {4'h0, convResult})
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        host_u.tick(4);
        t_defaults();
        t_short();
        t_test();
        t_cal();
        t_status();
        close_out();
    end
    // watchdog well beyond the 15 frames of traffic
    initial begin
        #500000;
        err_count++;
        close_out();
    end
endmodule // test_srd_top

// ===== hw/srd_cal_if.sv
// carrier between the frame logic and the calibration word store
`timescale 1ns/1ns
interface srd_cal_if #(
    parameter int AW = 2
);
    logic wrEn;
    logic [AW-1:0] addr;
    logic [13:0] wrData;
    logic [13:0] rdData;

    modport master (output wrEn, output addr, output wrData, input rdData);
    modport mem (input wrEn, input addr, input wrData, output rdData);
endinterface

// ===== hw/srd_cal_mem.sv
// small store for calibration words with registered read data
`timescale 1ns/1ns
module srd_cal_mem #(
    parameter int DEPTH = srd_pkg::CAL_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    srd_cal_if.mem bus
);
    typedef struct packed {
        logic [DEPTH-1:0][13:0] words;
        logic [13:0] rdData;
    } srd_mem_t;

    srd_mem_t state_reg;
    srd_mem_t state_next;

    // read takes the word as stored before any write this cycle, following the address every cycle
    always_comb begin
        state_next = state_reg;
        if (bus.wrEn) begin
            state_next.words[bus.addr] = bus.wrData; // RULE_05
        end
        state_next.rdData = state_reg.words[bus.addr];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.words <= {DEPTH{srd_pkg::CAL_RESET}};
            state_reg.rdData <= srd_pkg::CAL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.rdData = state_reg.rdData;
endmodule // srd_cal_mem

// ===== hw/srd_pkg.sv
// constants and state types of the serial register addressing block
// Behaviour
// RULE_01 - each write frame is 16 bits: 2 address bits then 14 data bits
// RULE_02 - registers change only after all 16 bits arrive; short frames discarded
// RULE_03 - address 00 selects nothing; the 14 data bits are dropped
// RULE_04 - address 01 stores the 14 data bits into the test word
// RULE_05 - address 10 stores data into the currently selected calibration word
// RULE_06 - address 11 stores the 14 data bits into the control word
// RULE_07 - control bits 7 and 6 choose the source of read frames
// RULE_08 - read select resets to 00, so reads give the conversion result
// RULE_09 - the chosen read source stays until read select is rewritten
// RULE_10 - conversion result reads carry four leading zero bits
// RULE_11 - read select 01 test, 10 calibration, 11 status
// RULE_12 - control write only; result, status read only; test, calibration both
// RULE_13 - host should never write the test word; factory use only
// RULE_14 - host needs only one write to choose channels; defaults suffice otherwise
// RULE_15 - every read result leaves the serial output as a 16-bit word
// RULE_16 - frame sync is active low, level sensitive, frames reads and writes
// RULE_17 - bits shift msb first, one per serial clock, while frame sync low
package srd_pkg;
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 14;
    localparam int RESULT_BITS = 12;
    localparam int CNT_BITS = 5;
    localparam int CAL_ADDR_BITS = 2;
    localparam int CAL_DEPTH = 4;
    // write address decode
    localparam logic [1:0] ADDR_NONE = 2'h0;
    localparam logic [1:0] ADDR_TEST = 2'h1;
    localparam logic [1:0] ADDR_CAL = 2'h2;
    localparam logic [1:0] ADDR_CTRL = 2'h3;
    // read select decode
    localparam logic [1:0] RD_RESULT = 2'h0;
    localparam logic [1:0] RD_TEST = 2'h1;
    localparam logic [1:0] RD_CAL = 2'h2;
    localparam logic [1:0] RD_STATUS = 2'h3;
    // field positions in the frame and in the control word
    localparam int ADDR_HI_POS = 15;
    localparam int ADDR_LO_POS = 14;
    localparam int RDSEL_HI_POS = 7;
    localparam int RDSEL_LO_POS = 6;
    localparam int CALSEL_HI_POS = 2;
    localparam int CALSEL_LO_POS = 1;
    localparam logic [3:0] RESULT_PAD = 4'h0;
    // reset values
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic [13:0] TEST_RESET = 14'h0000;
    localparam logic [13:0] CAL_RESET = 14'h0000;
    // pin idle levels {serial clock, frame sync, data}: clock low, sync high
    localparam logic [2:0] PIN_IDLE = 3'h2;
    localparam logic [4:0] CNT_LAST = 5'h0F;
    localparam logic [4:0] CNT_FULL = 5'h10;

    typedef struct packed {
        logic sclkPrev;
        logic inFrame;
        logic [4:0] bitCnt;
        logic [15:0] rxShift;
        logic [15:0] txShift;
        logic serialOut;
        logic [13:0] control;
        logic [13:0] test;
        logic writeDone;
    } srd_state_t;
endpackage

// ===== hw/srd_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module srd_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } srd_sync_t;

    srd_sync_t state_reg;
    srd_sync_t state_next;

    // first stage feeds only the second
    always_comb begin
        state_next.stage1 = async;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // reset to the pins' idle levels so no false frame follows
            state_reg.stage1 <= INIT;
            state_reg.stage2 <= INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    assign synced = state_reg.stage2;
endmodule // srd_sync

// ===== hw/srd_top.sv
// serial frame logic with write address decode and read select
`timescale 1ns/1ns
module srd_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic frameSyncN,
    input wire logic serialIn,
    output logic serialOut,
    input wire logic [11:0] convResult,
    input wire logic [15:0] devStatus,
    output logic [13:0] controlWord,
    output logic [13:0] testWord,
    output logic writeDone
);
    srd_pkg::srd_state_t state_reg;
    srd_pkg::srd_state_t state_next;

    logic [2:0] pinSync;
    logic sclkS;
    logic syncNS;
    logic dinS;
    logic sclkRise;
    logic sclkFall;
    logic [15:0] frameWord;
    logic frameComplete;
    logic calWrEn;
    logic [13:0] calWrData;
    logic [15:0] readWord;

    srd_cal_if #(.AW(srd_pkg::CAL_ADDR_BITS)) calBus ();

    // pins come from the host's domain, so they are synchronised first
    srd_sync #(.W(3), .INIT(srd_pkg::PIN_IDLE)) u_sync (
        .clk(clk),
        .rst(rst),
        .async({serialClk, frameSyncN, serialIn}),
        .synced(pinSync)
    );

    srd_cal_mem #(.DEPTH(srd_pkg::CAL_DEPTH)) u_cal (
        .clk(clk),
        .rst(rst),
        .bus(calBus)
    );

    assign sclkS = pinSync[2];
    assign syncNS = pinSync[1];
    assign dinS = pinSync[0];

    // calibration word picked by the control word's select field
    assign calBus.addr = state_reg.control[srd_pkg::CALSEL_HI_POS:
                                           srd_pkg::CALSEL_LO_POS];
    assign calBus.wrEn = calWrEn;
    assign calBus.wrData = calWrData;

    // read word for a given read select value
    function automatic logic [15:0] readMux(
        input logic [1:0] sel,
        input logic [11:0] result,
        input logic [13:0] test,
        input logic [13:0] cal,
        input logic [15:0] status
    );
        logic [15:0] w;
        w = 16'h0000;
        case (sel)
            srd_pkg::RD_RESULT: w = {srd_pkg::RESULT_PAD, result}; // RULE_10
            srd_pkg::RD_TEST: w = {2'h0, test}; // RULE_11
            srd_pkg::RD_CAL: w = {2'h0, cal}; // RULE_11
            srd_pkg::RD_STATUS: w = status; // RULE_11
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    // edges of the sampled serial clock; only act inside a frame
    assign sclkRise = sclkS & ~state_reg.sclkPrev;
    assign sclkFall = ~sclkS & state_reg.sclkPrev;

    // word as it stands once the current bit is shifted in, msb first
    assign frameWord = {state_reg.rxShift[14:0], dinS}; // RULE_17
    // the last bit completes the frame; nothing is stored before it
    assign frameComplete = state_reg.inFrame && !syncNS && sclkRise &&
                           (state_reg.bitCnt == srd_pkg::CNT_LAST); // RULE_02

    // read source held in control bits 7:6 until rewritten
    assign readWord = readMux(
        state_reg.control[srd_pkg::RDSEL_HI_POS:srd_pkg::RDSEL_LO_POS],
        convResult, state_reg.test, calBus.rdData, devStatus); // RULE_07 RULE_09

    // calibration write strobe, same cycle as the frame completes
    always_comb begin
        calWrEn = 1'b0;
        calWrData = frameWord[13:0];
        if (frameComplete &&
            frameWord[srd_pkg::ADDR_HI_POS:srd_pkg::ADDR_LO_POS] ==
            srd_pkg::ADDR_CAL) begin
            calWrEn = 1'b1; // RULE_05
        end
    end

    // frame tracking, shifting and register update
    always_comb begin
        state_next = state_reg;
        state_next.sclkPrev = sclkS;
        state_next.writeDone = 1'b0;
        if (syncNS) begin
            // sync high ends any frame; partial bits are dropped
            state_next.inFrame = 1'b0; // RULE_16
            state_next.bitCnt = 5'h00; // RULE_02
            state_next.rxShift = 16'h0000;
        end else if (!state_reg.inFrame) begin
            // frame start: load the read word, msb out at once
            state_next.inFrame = 1'b1; // RULE_16
            state_next.bitCnt = 5'h00;
            state_next.txShift = readWord; // RULE_15
            state_next.serialOut = readWord[15]; // RULE_17
        end else begin
            if (sclkRise && state_reg.bitCnt != srd_pkg::CNT_FULL) begin
                state_next.rxShift = frameWord; // RULE_17
                state_next.bitCnt = state_reg.bitCnt + 5'h01;
            end
            // later bits change on falling edges so the host samples on rise
            if (sclkFall && state_reg.bitCnt != 5'h00) begin
                state_next.txShift = {state_reg.txShift[14:0], 1'b0};
                state_next.serialOut = state_reg.txShift[14]; // RULE_15
            end
        end
        if (frameComplete) begin
            state_next.writeDone = 1'b1;
            case (frameWord[srd_pkg::ADDR_HI_POS:srd_pkg::ADDR_LO_POS])
                srd_pkg::ADDR_NONE: begin
                    // nothing addressed, data dropped
                    state_next.writeDone = 1'b1; // RULE_03
                end
                srd_pkg::ADDR_TEST: begin
                    state_next.test = frameWord[13:0]; // RULE_04 RULE_01
                end
                srd_pkg::ADDR_CAL: begin
                    // stored in the calibration store via the strobe
                    state_next.writeDone = 1'b1; // RULE_05
                end
                srd_pkg::ADDR_CTRL: begin
                    state_next.control = frameWord[13:0]; // RULE_06 RULE_01
                end
                default: begin
                    state_next.writeDone = 1'b1;
                end
            endcase
        end
    end

    // control resets to zero, so reads start on the conversion result
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg.sclkPrev <= 1'b0;
            state_reg.inFrame <= 1'b0;
            state_reg.bitCnt <= 5'h00;
            state_reg.rxShift <= 16'h0000;
            state_reg.txShift <= 16'h0000;
            state_reg.serialOut <= 1'b0;
            state_reg.control <= srd_pkg::CTRL_RESET; // RULE_08
            state_reg.test <= srd_pkg::TEST_RESET;
            state_reg.writeDone <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops; control is not readable serially
    assign serialOut = state_reg.serialOut;
    assign controlWord = state_reg.control; // RULE_12
    assign testWord = state_reg.test;
    assign writeDone = state_reg.writeDone;
endmodule // srd_top
